// ### rtl/tpd_pkg.sv
// Constants and types shared by the three-phase input decoder
package tpd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  TPD_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  TPD_STATUS_OFS   = 4'h4;
    localparam int          TPD_ADDR_W       = 4;

    // Control register fields
    localparam int          TPD_MODE_LSB     = 0;
    localparam int          TPD_MODE_W       = 2;
    localparam int          TPD_FREEWHEEL_BIT = 2;
    localparam logic [1:0]  TPD_MODE_RST     = 2'h0;
    localparam logic        TPD_FREEWHEEL_RST = 1'b0;

    // Status register fields
    localparam int          TPD_ST_GATE_HIGH_LSB = 0;
    localparam int          TPD_ST_GATE_LOW_LSB  = 3;
    localparam int          TPD_ST_CMD_HIGH_LSB  = 6;
    localparam int          TPD_ST_CMD_LOW_LSB   = 9;
    localparam int          TPD_ST_MODE_LSB      = 12;
    localparam int          TPD_ST_FREEWHEEL_BIT = 14;

    // Input scheme selector codes
    localparam logic [1:0]  TPD_MODE_SIX     = 2'h0;
    localparam logic [1:0]  TPD_MODE_THREE   = 2'h1;
    localparam logic [1:0]  TPD_MODE_SINGLE  = 2'h2;
    localparam logic [1:0]  TPD_MODE_INDEP   = 2'h3;

    // AXI4-Lite response codes
    localparam logic [1:0]  TPD_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  TPD_RESP_SLVERR  = 2'h2;

    // Phase bit positions inside three-bit vectors
    localparam int          TPD_PH_A         = 0;
    localparam int          TPD_PH_B         = 1;
    localparam int          TPD_PH_C         = 2;

    // Commutation step, one-hot
    typedef enum logic [7:0]
    {
        TPD_STEP_STOP  = 8'h01,
        TPD_STEP_ALIGN = 8'h02,
        TPD_STEP_BC    = 8'h04,
        TPD_STEP_AC    = 8'h08,
        TPD_STEP_AB    = 8'h10,
        TPD_STEP_CB    = 8'h20,
        TPD_STEP_CA    = 8'h40,
        TPD_STEP_BA    = 8'h80
    } tpd_step_t;

endpackage

// ### rtl/tpd_decoder.sv
// Three-phase gate command decoder with AXI4-Lite control and status
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps

module tpd_decoder
    import tpd_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // Gate command pins, bit 0 phase A, bit 2 phase C
    input  wire logic [2:0]            phase_high_cmd,
    input  wire logic [2:0]            phase_low_cmd,
    // Gate outputs
    output logic                       gate_high_a,
    output logic                       gate_low_a,
    output logic                       gate_high_b,
    output logic                       gate_low_b,
    output logic                       gate_high_c,
    output logic                       gate_low_c,
    // AXI4-Lite slave
    input  wire logic [TPD_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [TPD_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic [2:0]  hi_meta_q;
    logic [2:0]  lo_meta_q;
    logic [2:0]  hi_sync_q;
    logic [2:0]  lo_sync_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            hi_meta_q <= 3'h0;
            lo_meta_q <= 3'h0;
            hi_sync_q <= 3'h0;
            lo_sync_q <= 3'h0;
        end
        else
        begin
            hi_meta_q <= phase_high_cmd;
            lo_meta_q <= phase_low_cmd;
            hi_sync_q <= hi_meta_q;
            lo_sync_q <= lo_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Control register state
    // ------------------------------------------------------------
    logic [1:0]  mode_q;
    logic [1:0]  mode_d;
    logic        freewheel_q;
    logic        freewheel_d;

    // ------------------------------------------------------------
    // Single-PWM commutation decode
    // ------------------------------------------------------------
    logic        pwm;
    logic        direction;
    logic        brake_n;
    logic [2:0]  state_code;
    tpd_step_t   step;
    logic [2:0]  src;
    logic [2:0]  snk;

    // phase-A high input is the PWM
    assign pwm        = hi_sync_q[TPD_PH_A];
    assign direction  = hi_sync_q[TPD_PH_C];
    assign brake_n    = lo_sync_q[TPD_PH_C];
    assign state_code = {lo_sync_q[TPD_PH_A], hi_sync_q[TPD_PH_B], lo_sync_q[TPD_PH_B]};

    // Step lookup from state code and direction
    always_comb
    begin
        step = TPD_STEP_STOP;
        if (state_code == 3'h7)
        begin
            step = TPD_STEP_ALIGN;
        end
        else if (!direction)
        begin
            unique case (state_code)
                3'h6:    step = TPD_STEP_BC;
                3'h4:    step = TPD_STEP_AC;
                3'h5:    step = TPD_STEP_AB;
                3'h1:    step = TPD_STEP_CB;
                3'h3:    step = TPD_STEP_CA;
                3'h2:    step = TPD_STEP_BA;
                default: step = TPD_STEP_STOP;
            endcase
        end
        else
        begin
            unique case (state_code)
                3'h1:    step = TPD_STEP_BC;
                3'h3:    step = TPD_STEP_AC;
                3'h2:    step = TPD_STEP_AB;
                3'h6:    step = TPD_STEP_CB;
                3'h4:    step = TPD_STEP_CA;
                3'h5:    step = TPD_STEP_BA;
                default: step = TPD_STEP_STOP;
            endcase
        end
    end

    // Sourcing and sinking phases of the step, one bit per phase
    always_comb
    begin
        src = 3'h0;
        snk = 3'h0;
        unique case (step)
            TPD_STEP_ALIGN:
            begin
                src = 3'h1;
                snk = 3'h6;
            end
            TPD_STEP_BC:
            begin
                src = 3'h2;
                snk = 3'h4;
            end
            TPD_STEP_AC:
            begin
                src = 3'h1;
                snk = 3'h4;
            end
            TPD_STEP_AB:
            begin
                src = 3'h1;
                snk = 3'h2;
            end
            TPD_STEP_CB:
            begin
                src = 3'h4;
                snk = 3'h2;
            end
            TPD_STEP_CA:
            begin
                src = 3'h4;
                snk = 3'h1;
            end
            TPD_STEP_BA:
            begin
                src = 3'h2;
                snk = 3'h1;
            end
            default:
            begin
                src = 3'h0;
                snk = 3'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Gate output decode
    // ------------------------------------------------------------
    logic [2:0]  gate_high_q;
    logic [2:0]  gate_high_d;
    logic [2:0]  gate_low_q;
    logic [2:0]  gate_low_d;

    // Per-scheme gate decode
    always_comb
    begin
        gate_high_d = 3'h0;
        gate_low_d  = 3'h0;
        unique case (mode_q)
            TPD_MODE_SIX:
            begin
                gate_high_d = hi_sync_q & ~lo_sync_q;
                gate_low_d  = lo_sync_q & ~hi_sync_q;
            end
            TPD_MODE_THREE:
            begin
                // low input enables, high input picks gate
                gate_high_d = lo_sync_q & hi_sync_q;
                gate_low_d  = lo_sync_q & ~hi_sync_q;
            end
            TPD_MODE_SINGLE:
            begin
                if (!brake_n)
                begin
                    gate_high_d = 3'h0;
                    gate_low_d  = 3'h7;
                end
                else
                begin
                    // PWM on source, sink low on
                    gate_high_d = src & {3{pwm}};
                    gate_low_d  = snk | (src & {3{~pwm & ~freewheel_q}});
                end
            end
            TPD_MODE_INDEP:
            begin
                gate_high_d = hi_sync_q;
                gate_low_d  = lo_sync_q;
            end
            default:
            begin
                gate_high_d = 3'h0;
                gate_low_d  = 3'h0;
            end
        endcase
    end

    // Gate output registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gate_high_q <= 3'h0;
            gate_low_q  <= 3'h0;
        end
        else
        begin
            gate_high_q <= gate_high_d;
            gate_low_q  <= gate_low_d;
        end
    end

    assign gate_high_a = gate_high_q[TPD_PH_A];
    assign gate_high_b = gate_high_q[TPD_PH_B];
    assign gate_high_c = gate_high_q[TPD_PH_C];
    assign gate_low_a  = gate_low_q[TPD_PH_A];
    assign gate_low_b  = gate_low_q[TPD_PH_B];
    assign gate_low_c  = gate_low_q[TPD_PH_C];

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic                  awready_q, awready_d;
    logic                  wready_q, wready_d;
    logic                  aw_full_q, aw_full_d;
    logic                  w_full_q, w_full_d;
    logic [TPD_ADDR_W-1:0] waddr_q, waddr_d;
    logic [31:0]           wdata_q, wdata_d;
    logic [3:0]            wstrb_q, wstrb_d;
    logic                  bvalid_q, bvalid_d;
    logic [1:0]            bresp_q, bresp_d;
    logic                  arready_q, arready_d;
    logic                  rvalid_q, rvalid_d;
    logic [1:0]            rresp_q, rresp_d;
    logic [31:0]           rdata_q, rdata_d;
    logic [31:0]           status_word;

    // Live status: gate outputs, synchronised inputs, settings
    always_comb
    begin
        status_word = 32'h0;
        status_word[TPD_ST_GATE_HIGH_LSB +: 3] = gate_high_q;
        status_word[TPD_ST_GATE_LOW_LSB +: 3]  = gate_low_q;
        status_word[TPD_ST_CMD_HIGH_LSB +: 3]  = hi_sync_q;
        status_word[TPD_ST_CMD_LOW_LSB +: 3]   = lo_sync_q;
        status_word[TPD_ST_MODE_LSB +: 2]      = mode_q;
        status_word[TPD_ST_FREEWHEEL_BIT]      = freewheel_q;
    end

    // Bus next-state: address and data taken in either order
    always_comb
    begin
        aw_full_d   = aw_full_q;
        w_full_d    = w_full_q;
        waddr_d     = waddr_q;
        wdata_d     = wdata_q;
        wstrb_d     = wstrb_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        mode_d      = mode_q;
        freewheel_d = freewheel_q;
        rvalid_d    = rvalid_q;
        rresp_d     = rresp_q;
        rdata_d     = rdata_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_full_d = 1'b1;
            waddr_d   = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_full_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        // Commit once both halves are held
        if (aw_full_q && w_full_q)
        begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = TPD_RESP_OKAY;
            if (waddr_q == TPD_CTRL_OFS)
            begin
                if (wstrb_q[0])
                begin
                    mode_d      = wdata_q[TPD_MODE_LSB +: TPD_MODE_W];
                    freewheel_d = wdata_q[TPD_FREEWHEEL_BIT];
                end
            end
            else if (waddr_q != TPD_STATUS_OFS)
            begin
                bresp_d = TPD_RESP_SLVERR;
            end
        end
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = TPD_RESP_OKAY;
            rdata_d  = 32'h0;
            if (s_axi_araddr == TPD_CTRL_OFS)
            begin
                rdata_d[TPD_MODE_LSB +: TPD_MODE_W] = mode_q;
                rdata_d[TPD_FREEWHEEL_BIT]          = freewheel_q;
            end
            else if (s_axi_araddr == TPD_STATUS_OFS)
            begin
                rdata_d = status_word;
            end
            else
            begin
                rresp_d = TPD_RESP_SLVERR;
            end
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d  = !w_full_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // Bus registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            awready_q   <= 1'b0;
            wready_q    <= 1'b0;
            aw_full_q   <= 1'b0;
            w_full_q    <= 1'b0;
            waddr_q     <= '0;
            wdata_q     <= 32'h0;
            wstrb_q     <= 4'h0;
            bvalid_q    <= 1'b0;
            bresp_q     <= TPD_RESP_OKAY;
            mode_q      <= TPD_MODE_RST;
            freewheel_q <= TPD_FREEWHEEL_RST;
            arready_q   <= 1'b0;
            rvalid_q    <= 1'b0;
            rresp_q     <= TPD_RESP_OKAY;
            rdata_q     <= 32'h0;
        end
        else
        begin
            awready_q   <= awready_d;
            wready_q    <= wready_d;
            aw_full_q   <= aw_full_d;
            w_full_q    <= w_full_d;
            waddr_q     <= waddr_d;
            wdata_q     <= wdata_d;
            wstrb_q     <= wstrb_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            mode_q      <= mode_d;
            freewheel_q <= freewheel_d;
            arready_q   <= arready_d;
            rvalid_q    <= rvalid_d;
            rresp_q     <= rresp_d;
            rdata_q     <= rdata_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

endmodule

// ### sim/tpd_decoder_properties.sv
// Checker on the decoder's gate and register bus ports
`timescale 1ns/1ps
module tpd_decoder_props
    import tpd_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic [2:0]            phase_high_cmd,
    input wire logic [2:0]            phase_low_cmd,
    input wire logic                  gate_high_a,
    input wire logic                  gate_low_a,
    input wire logic                  gate_high_b,
    input wire logic                  gate_low_b,
    input wire logic                  gate_high_c,
    input wire logic                  gate_low_c,
    input wire logic [TPD_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic [31:0]           s_axi_wdata,
    input wire logic [3:0]            s_axi_wstrb,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [TPD_ADDR_W-1:0] s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid
);
    // ----------------------------------------
    // Shadow of scheme and pin history
    // ----------------------------------------
    logic [3:0] aw_q;
    logic [3:0] w_q;
    logic [1:0] mode_q;
    logic       fw_q;
    logic [2:0] quiet_q;
    logic [8:0] hp_q;
    logic [8:0] lp_q;
    logic [2:0] h3;
    logic [2:0] l3;
    logic [5:0] g;
    logic       ok;
    logic       run;

    // Pins three edges back, gate vector, settled flags
    assign h3  = hp_q[8:6];
    assign l3  = lp_q[8:6];
    assign g   = {gate_high_a, gate_low_a, gate_high_b, gate_low_b, gate_high_c, gate_low_c};
    assign ok  = quiet_q == 3'h7;
    assign run = ok && mode_q == TPD_MODE_SINGLE && l3[2];

    // Tracks committed writes; quiet counter masks gates around a change
    always_ff @(posedge clock)
    begin
        hp_q <= {hp_q[5:0], phase_high_cmd};
        lp_q <= {lp_q[5:0], phase_low_cmd};
        if (!rst_n)
        begin
            mode_q  <= 2'h0;
            fw_q    <= 1'b0;
            quiet_q <= 3'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                w_q <= {s_axi_wstrb[0], s_axi_wdata[2:0]};
            if (s_axi_bvalid && s_axi_bready && aw_q == TPD_CTRL_OFS && w_q[3])
                {fw_q, mode_q} <= w_q[2:0];
            if (s_axi_awvalid || s_axi_bvalid)
                quiet_q <= 3'h0;
            else if (!ok)
                quiet_q <= quiet_q + 3'h1;
        end
    end

    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_six_decode: assert property (
        ok && mode_q == TPD_MODE_SIX |-> g[5:4] == {h3[0] & ~l3[0], l3[0] & ~h3[0]})
        else $error("six-input decode wrong");
    a_three_decode: assert property (
        ok && mode_q == TPD_MODE_THREE |-> g[3:2] == (l3[1] ? {h3[1], ~h3[1]} : 2'h0))
        else $error("three-input decode wrong");
    a_brake_force: assert property (
        ok && mode_q == TPD_MODE_SINGLE && !l3[2] |-> g == 6'h15)
        else $error("brake did not force lows on");
    a_stop_off: assert property (
        run && {l3[0], h3[1], l3[1]} == 3'h0 |-> g == 6'h00)
        else $error("stop code left a gate on");
    a_align_drive: assert property (
        run && {l3[0], h3[1], l3[1]} == 3'h7 |-> g == {h3[0], ~h3[0] & ~fw_q, 4'h5})
        else $error("align drive wrong");
    a_step_dir: assert property (
        run && {l3[0], h3[1], l3[1]} == (h3[2] ? 3'h3 : 3'h4) |-> g == {h3[0], ~h3[0] & ~fw_q, 4'h1})
        else $error("A to C step wrong");
    a_indep_follow: assert property (
        ok && mode_q == TPD_MODE_INDEP |-> g == {h3[0], l3[0], h3[1], l3[1], h3[2], l3[2]})
        else $error("independent gates do not follow pins");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_unmapped_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr != TPD_CTRL_OFS && s_axi_araddr != TPD_STATUS_OFS
        |=> s_axi_rresp == TPD_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_resp_clear: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed");
endmodule

bind tpd_decoder tpd_decoder_props chk_u (.clock, .rst_n, .phase_high_cmd, .phase_low_cmd,
    .gate_high_a, .gate_low_a, .gate_high_b, .gate_low_b, .gate_high_c, .gate_low_c,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// ### sim/tpd_ctrl_model.sv
// Behavioural motor controller driving the six command pins
`timescale 1ns/1ps
module tpd_ctrl_model
(
    input  wire logic       clock,
    input  wire logic       quiesce,
    input  wire logic       half_bridge,
    input  wire logic [2:0] high_req,
    input  wire logic [2:0] low_req,
    output logic      [2:0] phase_high_cmd,
    output logic      [2:0] phase_low_cmd
);
    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // parked pins, no shoot-through pair while half_bridge is set
    always_ff @(posedge clock)
    begin
        phase_high_cmd <= quiesce ? 3'h0 : high_req;
        phase_low_cmd  <= quiesce ? 3'h0 : low_req & ~(high_req & {3{half_bridge}});
    end
endmodule

// ### sim/tpd_decoder_bench.sv
// Self-checking bench for the three-phase input decoder
`timescale 1ns/1ps
module tpd_decoder_bench
    import tpd_pkg::*;
;
    typedef struct packed
    {
        logic [1:0] mode;
        logic       fw;
        logic [2:0] h;
        logic [2:0] l;
        logic [5:0] g;
    } tpd_row_t;

    logic                  clock, rst_n, quiesce, half_bridge;
    logic [2:0]            high_req, low_req, cur, phase_high_cmd, phase_low_cmd;
    logic                  gate_high_a, gate_low_a, gate_high_b, gate_low_b, gate_high_c, gate_low_c;
    logic [5:0]            gates;
    logic [TPD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]           s_axi_wdata, s_axi_rdata;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int                    err_count, cmp_count;
    // ----------------------------------------
    // Rows: mode, freewheel, high pins, low pins, gates {ha,la,hb,lb,hc,lc}
    // ----------------------------------------
    // low pins held high, direction low, where unused
    tpd_row_t              rows [23] = '{
        '{2'h0, 1'h0, 3'h2, 3'h4, 6'h09}, '{2'h0, 1'h0, 3'h7, 3'h1, 6'h0A},
        '{2'h1, 1'h0, 3'h2, 3'h6, 6'h09}, '{2'h1, 1'h0, 3'h5, 3'h7, 6'h26},
        '{2'h2, 1'h0, 3'h1, 3'h4, 6'h00}, '{2'h2, 1'h0, 3'h3, 3'h7, 6'h25},
        '{2'h2, 1'h0, 3'h3, 3'h5, 6'h09}, '{2'h2, 1'h0, 3'h1, 3'h5, 6'h21},
        '{2'h2, 1'h0, 3'h1, 3'h7, 6'h24}, '{2'h2, 1'h0, 3'h1, 3'h6, 6'h06},
        '{2'h2, 1'h0, 3'h3, 3'h6, 6'h12}, '{2'h2, 1'h0, 3'h3, 3'h4, 6'h18},
        '{2'h2, 1'h0, 3'h5, 3'h6, 6'h09}, '{2'h2, 1'h0, 3'h7, 3'h6, 6'h21},
        '{2'h2, 1'h0, 3'h7, 3'h4, 6'h24}, '{2'h2, 1'h0, 3'h7, 3'h5, 6'h06},
        '{2'h2, 1'h0, 3'h5, 3'h5, 6'h12}, '{2'h2, 1'h0, 3'h5, 3'h7, 6'h18},
        '{2'h2, 1'h0, 3'h2, 3'h6, 6'h11}, '{2'h2, 1'h0, 3'h3, 3'h3, 6'h15},
        '{2'h2, 1'h1, 3'h2, 3'h6, 6'h10}, '{2'h2, 1'h1, 3'h2, 3'h7, 6'h05},
        '{2'h3, 1'h0, 3'h5, 3'h3, 6'h36}};

    assign gates = {gate_high_a, gate_low_a, gate_high_b, gate_low_b, gate_high_c, gate_low_c};

    tpd_ctrl_model ctrl_u (.clock, .quiesce, .half_bridge, .high_req, .low_req, .phase_high_cmd, .phase_low_cmd);

    tpd_decoder dut_u (.clock, .rst_n, .phase_high_cmd, .phase_low_cmd, .gate_high_a, .gate_low_a,
        .gate_high_b, .gate_low_b, .gate_high_c, .gate_low_c, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // Clock at 4 ns
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic no_answer;
        err_count++;
        $display("ERROR bus answer expected 1 seen 0");
        end_of_test;
    endtask

    // Write with both channels offered together, bready held until the answer
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit done;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        if (!done)
            no_answer();
        check("bresp", s_axi_bresp, er);
        // Edge apart, so back-to-back writes never drive bready twice at once
        @(posedge clock);
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        if (!done)
            no_answer();
        check("rdata", s_axi_rdata, ed);
        check("rresp", s_axi_rresp, er);
    endtask

    // Pins reach gates after model edge plus three-edge path
    task automatic apply(input logic [2:0] h, input logic [2:0] l);
        high_req <= h;
        low_req <= l;
        repeat (6) @(posedge clock);
    endtask

    task automatic set_scheme(input logic [2:0] fm);
        quiesce <= 1'b1;
        repeat (2) @(posedge clock);
        axi_write(TPD_CTRL_OFS, {29'h0, fm}, 4'h1, TPD_RESP_OKAY);
        quiesce <= 1'b0;
        cur = fm;
    endtask

    // Main sequence
    initial
    begin
        {rst_n, quiesce, half_bridge, high_req, low_req, cur} <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        axi_read(TPD_CTRL_OFS, 32'h0, TPD_RESP_OKAY);
        check("gates after reset", gates, 6'h00);
        $display("test reset done");
        foreach (rows[i])
        begin
            if ({rows[i].fw, rows[i].mode} != cur)
                set_scheme({rows[i].fw, rows[i].mode});
            apply(rows[i].h, rows[i].l);
            check("gates", gates, rows[i].g);
        end
        axi_read(TPD_STATUS_OFS, 32'h375D, TPD_RESP_OKAY);
        $display("test table done");
        axi_write(4'hC, 32'h2, 4'hF, TPD_RESP_SLVERR);
        axi_read(4'hC, 32'h0, TPD_RESP_SLVERR);
        axi_write(TPD_STATUS_OFS, 32'h0, 4'hF, TPD_RESP_OKAY);
        axi_write(TPD_CTRL_OFS, 32'h1, 4'h0, TPD_RESP_OKAY);
        axi_read(TPD_CTRL_OFS, 32'h3, TPD_RESP_OKAY);
        $display("test refusals done");
        half_bridge <= 1'b1;
        apply(3'h7, 3'h7);
        check("half-bridge gates", gates, 6'h2A);
        half_bridge <= 1'b0;
        // Split loads: overcurrent monitors assumed off, both gates on
        apply(3'h7, 3'h7);
        check("split-load gates", gates, 6'h3F);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        check("gates in reset", gates, 6'h00);
        rst_n <= 1'b1;
        @(posedge clock);
        axi_read(TPD_CTRL_OFS, 32'h0, TPD_RESP_OKAY);
        apply(3'h7, 3'h7);
        check("six-input both high", gates, 6'h00);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
